// File: verilog/rsq_top.sv
/*
 * relay output sequencer with input status message generation
 * assumes apb3 master on CLK_SYS, pins asynchronous to the clock
 */
// The APB interface to the registers and the register addresses were decided locally.
// Notes on behaviour
// - pulse mode alternates after manual activate
// - continuous sub-mode pulses without end
// - counted sub-mode gives exact pulse count
// - inactive width 1..9999 units, default one
// - active width 1..9999 units, default one
// - delay then active in inactive-to-active mode
// - active then inactive after delay
// - deactivate postponed by programmed delay
// - failsafe action none, activate or deactivate
// - input change messages all its sessions
// - one-way messages, no reply awaited
// - one message per input, only on change
// - message exactly twenty bytes long
// - type, number, address, alarm, status order
// - type zero digital, one serial
// - number 1-4 digital, 5-7 handshake
// - alarm byte zero or one
// - status byte zero or one
// - ten reserved bytes are zero
// - output bound to at most one input
`timescale 1ns/1ps
`default_nettype none
module rsq_top #(
	parameter int TICK_CYCLES = rsq_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                      CLK_SYS,
	input  wire logic                      RSTN,
	// apb slave
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [7:0]                PADDR,
	input  wire logic [31:0]               PWDATA,
	output logic      [31:0]               PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	// input pins
	input  wire logic [rsq_pkg::N_DIN-1:0] DIN,
	input  wire logic [rsq_pkg::N_HS-1:0]  HS_IN,
	input  wire logic                      FAILSAFE_TRIG,
	// relay drive
	output logic                           RELAY_OUT,
	// status message stream
	output logic [7:0]                     MSG_DATA,
	output logic                           MSG_VALID,
	output logic                           MSG_FIRST,
	output logic                           MSG_LAST,
	output logic [rsq_pkg::N_SESS-1:0]     MSG_SESS
);
	import rsq_pkg::*;

	// ==========================================
	// configuration registers
	rsq_mode_t     mode_reg;    // output mode
	logic          counted_reg; // counted pulse sub-mode
	rsq_fs_t       fs_reg;      // failsafe action
	logic          link_reg;    // relay follows an input
	logic [2:0]    src_reg;     // the one linked input
	logic [WW-1:0] pcount_reg;  // pulses in counted mode
	logic [WW-1:0] inactw_reg;  // inactive phase width
	logic [WW-1:0] actw_reg;    // active phase width
	logic [WW-1:0] delay_reg;   // delay value
	logic [47:0]   mac_reg;     // sender address
	logic [N_IN-1:0] alpol_reg; // level that means alarm
	logic [N_SESS*N_IN-1:0] sess_reg; // sessions per input
	logic          cmd_act;     // one-cycle activate
	logic          cmd_deact;   // one-cycle deactivate
	// ==========================================
	// block state
	rsq_state_t    state_reg, state_next; // relay sequencer
	logic [WW-1:0] tmr_reg, tmr_next;     // phase timer
	logic [WW-1:0] left_reg, left_next;   // pulses left
	logic          out_next;              // relay next level
	logic          tick;                  // 100 ms pulse
	logic [$clog2(TICK_CYCLES)-1:0] tdiv_reg; // tick divider
	logic [N_IN:0] pin_s;                 // synchronised pins
	logic [N_IN-1:0] lvl_reg;             // last input levels
	logic [N_IN-1:0] chg;                 // input changed
	logic [N_IN-1:0] pend_reg;            // message owed
	logic          fs_s, fs_d_reg, fs_fire; // failsafe edge
	logic          tx_busy, tx_start;     // serialiser control
	logic [2:0]    pick;                  // input to report
	rsq_hdr_t      hdr;                   // fields of message
	logic          expire;                // phase timer done
	logic          wr, rd_setup;          // apb phases

	// clamp a written width into 1..9999
	function automatic logic [WW-1:0] clamp_w(input logic [31:0] v);
		if (v == 32'h0) begin
			return W_DFLT;
		end else if (v > 32'(W_MAX)) begin
			return W_MAX;
		end
		return v[WW-1:0];
	endfunction

	// offset known to the register map
	function automatic logic mapped(input logic [7:0] a);
		return (a <= OFS_STATUS) && (a[1:0] == 2'b00);
	endfunction

	// ==========================================
	// apb slave
	assign wr       = PSEL && PENABLE && PWRITE && mapped(PADDR);
	assign rd_setup = PSEL && !PENABLE;
	assign PREADY   = 1'b1; // no wait states

	// configuration writes
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mode_reg    <= MODE_MANUAL;
			counted_reg <= 1'b0;
			fs_reg      <= FS_NONE;
			link_reg    <= 1'b0;
			src_reg     <= 3'h0;
			pcount_reg  <= W_DFLT;
			inactw_reg  <= W_DFLT;
			actw_reg    <= W_DFLT;
			delay_reg   <= W_DFLT;
			mac_reg     <= '0;
			alpol_reg   <= '1;
			sess_reg    <= '0;
		end else if (wr) begin
			case (PADDR)
				OFS_CTRL: begin
					mode_reg    <= rsq_mode_t'(PWDATA[CTRL_MODE+:2]);
					counted_reg <= PWDATA[CTRL_CNT];
					fs_reg      <= rsq_fs_t'(PWDATA[CTRL_FS+:2]);
					link_reg    <= PWDATA[CTRL_LINK];
					src_reg     <= PWDATA[CTRL_SRC+:3];
				end
				OFS_PCOUNT: pcount_reg <= clamp_w(PWDATA);
				OFS_INACTW: inactw_reg <= clamp_w(PWDATA);
				OFS_ACTW:   actw_reg   <= clamp_w(PWDATA);
				OFS_DELAY:  delay_reg  <= clamp_w(PWDATA);
				OFS_MAC_LO: mac_reg[31:0]  <= PWDATA;
				OFS_MAC_HI: mac_reg[47:32] <= PWDATA[15:0];
				OFS_ALPOL:  alpol_reg  <= PWDATA[N_IN-1:0];
				OFS_SESSLO: sess_reg[31:0] <= PWDATA;
				OFS_SESSHI: sess_reg[N_SESS*N_IN-1:32] <= PWDATA[23:0];
				default: ;
			endcase
		end
	end

	// command strobes, written bits act once
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			cmd_act   <= 1'b0;
			cmd_deact <= 1'b0;
		end else begin
			cmd_act   <= (wr && PADDR == OFS_CMD && PWDATA[CMD_ACT])
				|| (link_reg && chg[src_reg] && pin_s[src_reg]);
			cmd_deact <= (wr && PADDR == OFS_CMD && PWDATA[CMD_DEACT])
				|| (link_reg && chg[src_reg] && !pin_s[src_reg]);
		end
	end

	// read data prepared in the setup phase
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end else if (rd_setup) begin
			PSLVERR <= !mapped(PADDR);
			case (PADDR)
				OFS_CTRL:   PRDATA <= {20'h0, src_reg, link_reg, 3'h0,
					fs_reg, counted_reg, mode_reg};
				OFS_PCOUNT: PRDATA <= {18'h0, pcount_reg};
				OFS_INACTW: PRDATA <= {18'h0, inactw_reg};
				OFS_ACTW:   PRDATA <= {18'h0, actw_reg};
				OFS_DELAY:  PRDATA <= {18'h0, delay_reg};
				OFS_MAC_LO: PRDATA <= mac_reg[31:0];
				OFS_MAC_HI: PRDATA <= {16'h0, mac_reg[47:32]};
				OFS_ALPOL:  PRDATA <= {25'h0, alpol_reg};
				OFS_SESSLO: PRDATA <= sess_reg[31:0];
				OFS_SESSHI: PRDATA <= {8'h0, sess_reg[N_SESS*N_IN-1:32]};
				OFS_STATUS: PRDATA <= {13'h0, tx_busy, pend_reg,
					lvl_reg, state_reg, RELAY_OUT};
				default:    PRDATA <= 32'h0; // command and holes
			endcase
		end
	end

	// ==========================================
	// time base
	// one tick every TICK_CYCLES edges
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			tdiv_reg <= '0;
			tick     <= 1'b0;
		end else if (tdiv_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
			tdiv_reg <= '0;
			tick     <= 1'b1;
		end else begin
			tdiv_reg <= tdiv_reg + 1'b1;
			tick     <= 1'b0;
		end
	end

	// ==========================================
	// relay sequencer
	assign expire = tick && (tmr_reg == W_DFLT);

	// next state, failsafe first, then commands, then timer
	always_comb begin
		state_next = state_reg;
		tmr_next   = (tick && tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
		left_next  = left_reg;
		if (fs_fire && fs_reg == FS_ACT) begin
			state_next = ST_ON;
		end else if (fs_fire && fs_reg == FS_DEACT) begin
			state_next = ST_OFF;
		end else if (cmd_act) begin
			case (mode_reg)
				MODE_MANUAL: state_next = ST_ON;
				MODE_PULSE: begin
					state_next = ST_PACT;
					tmr_next   = actw_reg;
					left_next  = pcount_reg;
				end
				MODE_I2A: begin
					state_next = ST_I2A;
					tmr_next   = delay_reg;
				end
				default: begin
					state_next = ST_A2I;
					tmr_next   = delay_reg;
				end
			endcase
		end else if (cmd_deact && state_reg != ST_OFF) begin
			if (state_reg != ST_DWAIT) begin
				state_next = ST_DWAIT;
				tmr_next   = delay_reg;
			end
		end else if (expire) begin
			case (state_reg)
				ST_PACT: begin
					state_next = ST_PINACT;
					tmr_next   = inactw_reg;
				end
				ST_PINACT: begin
					if (counted_reg && left_reg == W_DFLT) begin
						state_next = ST_OFF;
					end else begin
						state_next = ST_PACT;
						tmr_next   = actw_reg;
						left_next  = counted_reg ? left_reg - 1'b1 : left_reg;
					end
				end
				ST_I2A:   state_next = ST_ON;
				ST_A2I:   state_next = ST_OFF;
				ST_DWAIT: state_next = ST_OFF;
				default:  state_next = state_reg;
			endcase
		end
	end

	// relay level follows the state, held while a deactivate waits
	always_comb begin
		case (state_next)
			ST_ON, ST_PACT, ST_A2I: out_next = 1'b1;
			ST_DWAIT:               out_next = RELAY_OUT;
			default:                out_next = 1'b0;
		endcase
	end

	// sequencer registers, reset leaves the relay inactive
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= ST_OFF;
			tmr_reg   <= '0;
			left_reg  <= '0;
			RELAY_OUT <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg   <= tmr_next;
			left_reg  <= left_next;
			RELAY_OUT <= out_next;
		end
	end

	// ==========================================
	// inputs and change detection
	rsq_sync2 #(
		.W     (N_IN + 1)
	) u_sync (
		.clk   (CLK_SYS),
		.rst_n (RSTN),
		.d     ({FAILSAFE_TRIG, HS_IN, DIN}),
		.q     (pin_s)
	);
	assign fs_s    = pin_s[N_IN];
	assign fs_fire = fs_s && !fs_d_reg;
	assign chg     = pin_s[N_IN-1:0] ^ lvl_reg;

	// level history and owed messages, a new change beats a clear
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			lvl_reg  <= '0;
			fs_d_reg <= 1'b0;
			pend_reg <= '0;
		end else begin
			lvl_reg  <= pin_s[N_IN-1:0];
			fs_d_reg <= fs_s;
			pend_reg <= (pend_reg & ~(tx_start ? N_IN'(1) << pick : '0))
				| chg;
		end
	end

	// lowest owed input goes first
	always_comb begin
		pick = 3'h0;
		for (int i = N_IN - 1; i >= 0; i--) begin
			if (pend_reg[i]) begin
				pick = 3'(i);
			end
		end
	end
	assign tx_start = (pend_reg != '0) && !tx_busy;

	// message fields for the chosen input
	always_comb begin
		hdr.kind   = (pick >= 3'(N_DIN)) ? TYPE_SER : TYPE_DIG;
		hdr.num    = 8'(pick) + BYTE_ONE;
		hdr.mac    = mac_reg;
		hdr.alarm  = (lvl_reg[pick] == alpol_reg[pick]) ? BYTE_ONE : BYTE_ZERO;
		hdr.status = lvl_reg[pick] ? BYTE_ONE : BYTE_ZERO;
		hdr.sess   = sess_reg[pick*N_SESS+:N_SESS];
	end

	rsq_msg_tx u_tx (
		.clk   (CLK_SYS),
		.rst_n (RSTN),
		.start (tx_start),
		.hdr   (hdr),
		.busy  (tx_busy),
		.data  (MSG_DATA),
		.valid (MSG_VALID),
		.first (MSG_FIRST),
		.last  (MSG_LAST),
		.sess  (MSG_SESS)
	);

	// ==========================================
	// checks
	property p_manual_act;
		@(posedge CLK_SYS) disable iff (!RSTN)
		cmd_act && mode_reg == MODE_MANUAL && !fs_fire |=> RELAY_OUT;
	endproperty
	a_manual_act: assert property (p_manual_act) else $error("manual activate lost");
	property p_pulse_start;
		@(posedge CLK_SYS) disable iff (!RSTN)
		cmd_act && mode_reg == MODE_PULSE && !fs_fire |=> state_reg == ST_PACT && RELAY_OUT;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");
	property p_continuous;
		@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_PINACT && expire && !counted_reg && !cmd_act && !cmd_deact && !fs_fire
		|=> state_reg == ST_PACT;
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous pulse stopped");
	property p_count_stop;
		@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_PINACT && expire && counted_reg && left_reg == W_DFLT
		&& !cmd_act && !fs_fire |=> state_reg == ST_OFF && !RELAY_OUT;
	endproperty
	a_count_stop: assert property (p_count_stop) else $error("counted pulse overran");
	property p_i2a_low;
		@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_I2A |-> !RELAY_OUT;
	endproperty
	a_i2a_low: assert property (p_i2a_low) else $error("active during delay");
	property p_a2i_high;
		@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_A2I |-> RELAY_OUT;
	endproperty
	a_a2i_high: assert property (p_a2i_high) else $error("inactive during delay");
	property p_deact_hold;
		@(posedge CLK_SYS) disable iff (!RSTN)
		cmd_deact && !cmd_act && !fs_fire && state_reg != ST_OFF && state_reg != ST_DWAIT
		|=> state_reg == ST_DWAIT && RELAY_OUT == $past(RELAY_OUT);
	endproperty
	a_deact_hold: assert property (p_deact_hold) else $error("deactivate not postponed");
	property p_fs_act;
		@(posedge CLK_SYS) disable iff (!RSTN)
		fs_fire && fs_reg == FS_ACT |=> RELAY_OUT;
	endproperty
	a_fs_act: assert property (p_fs_act) else $error("failsafe activate ignored");
	property p_msg_len;
		@(posedge CLK_SYS) disable iff (!RSTN)
		MSG_FIRST |-> (MSG_VALID [*8] ##1 MSG_VALID [*8] ##1 MSG_VALID [*4] ##1 !MSG_VALID)
			and (##19 MSG_LAST);
	endproperty
	a_msg_len: assert property (p_msg_len) else $error("message length wrong");
	property p_tick_once;
		@(posedge CLK_SYS) disable iff (!RSTN)
		tick |=> !tick;
	endproperty
	a_tick_once: assert property (p_tick_once) else $error("tick longer than a cycle");
	c_pulse: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_PINACT ##1 state_reg == ST_PACT);
	c_dwait: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_DWAIT ##1 state_reg == ST_OFF);
	c_msg: cover property (@(posedge CLK_SYS) disable iff (!RSTN) MSG_LAST);
endmodule
`default_nettype wire

// File: common/rsq_pkg.sv
/*
 * constants, enumerations and carrier types of the relay sequencer
 * assumes a 20 MHz system clock and a 32-bit apb register bus
 */
`default_nettype none
package rsq_pkg;
	// ==========================================
	// timing
	localparam int CLK_HZ      = 20_000_000; // system clock rate
	localparam int TICK_MS     = 100;        // timing unit in ms
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// ==========================================
	// sizes
	localparam int WW     = 14; // width of a 1..9999 field
	localparam int N_DIN  = 4;  // digital inputs
	localparam int N_HS   = 3;  // handshake inputs dsr dcd cts
	localparam int N_IN   = 7;  // all reported inputs
	localparam int N_SESS = 8;  // sessions per input
	localparam int MSG_LEN  = 20; // bytes per message
	localparam int MSG_USED = 10; // bytes with fields
	localparam logic [WW-1:0] W_DFLT = 14'h0001; // one unit
	localparam logic [WW-1:0] W_MAX  = 14'h270f; // 9999 units
	// ==========================================
	// register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_PCOUNT = 8'h08;
	localparam logic [7:0] OFS_INACTW = 8'h0c;
	localparam logic [7:0] OFS_ACTW   = 8'h10;
	localparam logic [7:0] OFS_DELAY  = 8'h14;
	localparam logic [7:0] OFS_MAC_LO = 8'h18;
	localparam logic [7:0] OFS_MAC_HI = 8'h1c;
	localparam logic [7:0] OFS_ALPOL  = 8'h20;
	localparam logic [7:0] OFS_SESSLO = 8'h24;
	localparam logic [7:0] OFS_SESSHI = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2c;
	// ==========================================
	// field positions and reset values
	localparam int CTRL_MODE  = 0; // [1:0] output mode
	localparam int CTRL_CNT   = 2; // counted pulse sub-mode
	localparam int CTRL_FS    = 3; // [4:3] failsafe action
	localparam int CTRL_LINK  = 8; // relay follows an input
	localparam int CTRL_SRC   = 9; // [11:9] linked input index
	localparam int CMD_ACT    = 0;
	localparam int CMD_DEACT  = 1;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// ==========================================
	// message bytes
	localparam logic [7:0] TYPE_DIG = 8'h00;
	localparam logic [7:0] TYPE_SER = 8'h01;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'h0, MODE_PULSE = 2'h1, MODE_I2A = 2'h2, MODE_A2I = 2'h3
	} rsq_mode_t;
	typedef enum logic [1:0] {
		FS_NONE = 2'h0, FS_ACT = 2'h1, FS_DEACT = 2'h2
	} rsq_fs_t;
	typedef enum logic [2:0] {
		ST_OFF = 3'h0, ST_ON = 3'h1, ST_PACT = 3'h3, ST_PINACT = 3'h2,
		ST_I2A = 3'h6, ST_A2I = 3'h7, ST_DWAIT = 3'h5
	} rsq_state_t;
	typedef struct packed {
		logic [7:0]        kind;   // message type byte
		logic [7:0]        num;    // input number byte
		logic [47:0]       mac;    // sender hardware address
		logic [7:0]        alarm;  // alarm state byte
		logic [7:0]        status; // input status byte
		logic [N_SESS-1:0] sess;   // sessions to deliver to
	} rsq_hdr_t;
endpackage
`default_nettype wire

// File: verilog/rsq_sync2.sv
/*
 * two flip-flop level synchroniser, width is a parameter
 * assumes levels that stay put for several clock cycles
 */
`timescale 1ns/1ps
`default_nettype none
module rsq_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	// ==========================================
	// stages
	logic [W-1:0] meta_reg; // first stage, read only by q

	// two stages, constants under reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// File: verilog/rsq_msg_tx.sv
/*
 * serialiser of one twenty-byte status message, a byte a cycle
 * assumes a start only while not busy; no reply is awaited
 */
`timescale 1ns/1ps
`default_nettype none
module rsq_msg_tx
	import rsq_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// message request
	input  wire logic             start,
	input  wire rsq_pkg::rsq_hdr_t hdr,
	output logic                  busy,
	// byte stream
	output logic [7:0]            data,
	output logic                  valid,
	output logic                  first,
	output logic                  last,
	output logic [N_SESS-1:0]     sess
);
	// ==========================================
	// state
	rsq_hdr_t   hdr_reg; // captured fields
	logic [4:0] idx_reg; // byte index
	logic [7:0] byte_next; // byte for this index

	// byte selection in field order
	always_comb begin
		byte_next = BYTE_ZERO; // reserved bytes are zero
		case (idx_reg)
			5'h00: byte_next = hdr_reg.kind;
			5'h01: byte_next = hdr_reg.num;
			5'h02: byte_next = hdr_reg.mac[47:40];
			5'h03: byte_next = hdr_reg.mac[39:32];
			5'h04: byte_next = hdr_reg.mac[31:24];
			5'h05: byte_next = hdr_reg.mac[23:16];
			5'h06: byte_next = hdr_reg.mac[15:8];
			5'h07: byte_next = hdr_reg.mac[7:0];
			5'h08: byte_next = hdr_reg.alarm;
			5'h09: byte_next = hdr_reg.status;
			default: byte_next = BYTE_ZERO;
		endcase
	end

	// sequencing, one byte per edge, nothing awaited back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy    <= 1'b0;
			idx_reg <= 5'h00;
			hdr_reg <= '0;
		end else if (start && !busy) begin
			busy    <= 1'b1;
			idx_reg <= 5'h00;
			hdr_reg <= hdr;
		end else if (busy) begin
			if (idx_reg == 5'(MSG_LEN - 1)) begin
				busy <= 1'b0;
			end
			idx_reg <= idx_reg + 5'h01;
		end
	end

	// registered stream outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data  <= 8'h00;
			valid <= 1'b0;
			first <= 1'b0;
			last  <= 1'b0;
			sess  <= '0;
		end else begin
			data  <= busy ? byte_next : 8'h00;
			valid <= busy;
			first <= busy && (idx_reg == 5'h00);
			last  <= busy && (idx_reg == 5'(MSG_LEN - 1));
			sess  <= hdr_reg.sess;
		end
	end

	// ==========================================
	// checks
	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		busy && (idx_reg >= 5'(MSG_USED)) |=> valid && (data == 8'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");
endmodule
`default_nettype wire

// File: testbench/rsq_rx_model.sv
/*
 * receiver model of the status message stream
 * assumes one byte a cycle framed by first and last
 */
`timescale 1ns/1ps
`default_nettype none
module rsq_rx_model
	import rsq_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// message stream
	input  wire logic [7:0]        data,
	input  wire logic              valid,
	input  wire logic              first,
	input  wire logic              last,
	input  wire logic [N_SESS-1:0] sess,
	// decoded result
	output logic [7:0]             msg [20],
	output int                     n_msg,
	output int                     n_len,
	output logic [N_SESS-1:0]      got_sess
);
	int idx; // byte position in frame
	// collect bytes; the sender gets no reply
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx = 0;
			n_msg = 0;
			n_len = 0;
		end else if (valid) begin
			if (first) idx = 0;
			if (idx < 20) msg[idx] = data;
			idx = idx + 1;
			got_sess = sess;
			// keep only known types, else skip the block
			if (last && (msg[0] == TYPE_DIG || msg[0] == TYPE_SER)) begin
				n_len = idx;
				n_msg = n_msg + 1;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/rsq_top_tb_top.sv
/*
 * self-checking bench of the relay sequencer
 * assumes a 10-cycle tick and a zero-wait apb slave
 */
`timescale 1ns/1ps
`default_nettype none
module rsq_top_tb_top;
	import rsq_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, fs = 0, pe;
	logic [7:0] pa = 0, md [20], ex [10];
	logic [31:0] pw = 0, pr, rd;
	logic [3:0] din = 0;
	logic [2:0] hs = 0;
	logic relay, mv, mf, ml, pready, perr;
	logic [7:0] mdat;
	logic [N_SESS-1:0] ms, gs;
	int bad_count = 0, num_checks = 0, cyc = 0, nm, nl, k;
	// ==========================================
	// clock, design and receiver
	always #25 clk = ~clk;
	rsq_top #(.TICK_CYCLES(10)) dut_u (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(pr),
		.PREADY(pready), .PSLVERR(perr), .DIN(din), .HS_IN(hs), .FAILSAFE_TRIG(fs),
		.RELAY_OUT(relay), .MSG_DATA(mdat), .MSG_VALID(mv), .MSG_FIRST(mf),
		.MSG_LAST(ml), .MSG_SESS(ms));
	rsq_rx_model rx_u (.clk(clk), .rst_n(rstn), .data(mdat), .valid(mv), .first(mf),
		.last(ml), .sess(ms), .msg(md), .n_msg(nm), .n_len(nl), .got_sess(gs));
	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = pr;
		pe = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// count rising relay edges over a fixed window
	task automatic rises(output int n);
		logic pv;
		n = 0;
		pv = relay;
		for (k = 0; k < 200; k++) begin
			cyc_wait(1);
			if (relay === 1'b1 && pv === 1'b0) n++;
			pv = relay;
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs;
		apb(0, OFS_CTRL, 0); chk(rd, RST_ZERO);
		for (k = 8; k <= 20; k += 4) begin
			apb(0, k[7:0], 0); chk(rd, 32'h1);
		end
		apb(1, OFS_ACTW, 32'hffff); apb(0, OFS_ACTW, 0); chk(rd, {18'h0, W_MAX});
		apb(0, 8'h30, 0); chk({31'h0, pe}, 32'h1);
	endtask
	task automatic t_manual;
		apb(1, OFS_DELAY, 3); apb(1, OFS_CMD, 1); cyc_wait(3); chk(relay, 1);
		apb(1, OFS_CMD, 2); cyc_wait(15); chk(relay, 1);
		for (k = 0; k < 40 && relay !== 1'b0; k++) cyc_wait(1);
		chk(relay, 0);
	endtask
	// delayed modes, each started from an inactive relay
	task automatic t_delay;
		apb(1, OFS_CTRL, 3); apb(1, OFS_CMD, 1); cyc_wait(3); chk(relay, 1);
		for (k = 0; k < 40 && relay !== 1'b0; k++) cyc_wait(1);
		chk(relay, 0);
		apb(1, OFS_CTRL, 2); apb(1, OFS_CMD, 1); cyc_wait(3); chk(relay, 0);
		for (k = 0; k < 40 && relay !== 1'b1; k++) cyc_wait(1);
		chk(relay, 1);
		apb(1, OFS_CMD, 2); cyc_wait(40); chk(relay, 0);
	endtask
	task automatic t_pulse;
		int np;
		apb(1, OFS_CTRL, 5); apb(1, OFS_PCOUNT, 2); apb(1, OFS_INACTW, 2);
		apb(1, OFS_ACTW, 2); apb(1, OFS_CMD, 1);
		rises(np);
		chk(np, 2); chk(relay, 0);
		apb(1, OFS_CTRL, 1); apb(1, OFS_CMD, 1);
		rises(np);
		chk(np >= 4, 1);
		apb(1, OFS_CMD, 2); cyc_wait(40); chk(relay, 0);
	endtask
	task automatic t_fs;
		apb(1, OFS_CTRL, 32'h8); fs <= 1; cyc_wait(6); chk(relay, 1);
		@(posedge clk); fs <= 0;
		apb(1, OFS_CTRL, 32'h10); fs <= 1; cyc_wait(6); chk(relay, 0);
		@(posedge clk); fs <= 0;
		apb(1, OFS_CTRL, 32'h0); fs <= 1; cyc_wait(6); chk(relay, 0);
		@(posedge clk); fs <= 0;
	endtask
	task automatic wmsg(input int n0);
		for (k = 0; k < 80 && nm == n0; k++) cyc_wait(1);
		chk(nl, MSG_LEN);
	endtask
	task automatic t_msg;
		apb(1, OFS_MAC_LO, 32'h33445566); apb(1, OFS_MAC_HI, 32'h1122);
		apb(1, OFS_SESSLO, 32'ha500); apb(1, OFS_CTRL, 32'h300);
		ex = '{8'h00, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h01, 8'h01};
		din <= 4'h2; wmsg(nm);
		for (k = 0; k < 10; k++) chk(md[k], ex[k]);
		for (k = 10; k < 20; k++) chk(md[k], BYTE_ZERO);
		chk(gs, 8'ha5);
		chk(relay, 1);
		@(posedge clk); hs <= 3'h4; wmsg(nm);
		chk({md[0], md[1], md[9]}, {TYPE_SER, 8'h07, BYTE_ONE});
		chk(relay, 1);
	endtask
	// ==========================================
	// sequence and timeout
	always @(posedge clk) if (++cyc == 20000) begin
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		t_regs(); t_manual(); t_delay(); t_pulse(); t_fs(); t_msg();
		stop_test();
	end
endmodule
`default_nettype wire
